// ### hdl/msd_pkg.sv
// Shared constants, field layout and helpers for the stepper driver serial link
//
// Behaviour
// - Sleep: drivers high impedance, analog low power
// - Controller sends no steps while asleep
// - Sleep stops clocks except during serial exchange
// - Hard reset input works during sleep
// - Watchdog count freezes in sleep, then resumes
// - Controller waits charge pump start after wake by a sleep-bit write; a hard reset clears sleep with no wait
// - Watchdog timeout is 32 ms times (code+1)
// - Device is slave only, never starts transfers
// - Mode 0: out on falling, sample rising
// - Output released high when not selected
// - Packets are bytes sent MSB first
// - First byte: command bit, 5-bit register select
// - Eighth falling edge loads addressed register for output
// - Byte during read reply is next command
// - Status reads carry even parity top bit
// - Controller rereads status on parity mismatch
// - Status clears on read, updates only deselected
// - Controller raises select right after each packet
// - Write commits first clock after deselect
// - Every byte returns last addressed register
// - Write needs exactly 16 bits, else discarded
// - Writes to read-only registers change nothing
// - Watchdog rewrite too early or late pulses reset
`default_nettype none

package msd_pkg;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_KHZ      = 25000;
    localparam int TICK_MS      = 1;
    localparam int MS_CYC       = TICK_MS * CLK_KHZ;
    localparam int WD_BASE_MS   = 32;
    localparam int WD_EARLY_MS  = 4;
    localparam int WD_PULSE_CYC = 16;
    localparam int CP_START_US  = 1000;
    localparam int CP_CYC       = CP_START_US * CLK_KHZ / 1000;
    localparam int SPI_HALF     = 10;
    localparam int STEP_HI_CYC  = 4;
    localparam int WR_BITS      = 16;

    // ****************************************************
    // Device register select codes and fields
    // ****************************************************
    localparam logic [4:0] A_WR  = 5'h00;
    localparam logic [4:0] A_CR2 = 5'h03;
    localparam logic [4:0] A_SR0 = 5'h04;
    localparam logic [4:0] A_SR3 = 5'h07;
    localparam logic [4:0] A_CR3 = 5'h08;
    localparam logic [2:0] CR3_IDX   = 3'h4;
    localparam int         NCTRL     = 5;
    localparam int         CMD_BIT   = 7;
    localparam int         WATCHDOG_ENABLE_BIT_BIT  = 7;
    localparam int         WDT_LSB   = 3;
    localparam int         SLP_BIT   = 6;
    localparam int         MOTEN_BIT = 7;

    // ****************************************************
    // Controller APB map
    // ****************************************************
    localparam logic [7:0] H_CMD  = 8'h00;
    localparam logic [7:0] H_STAT = 8'h04;
    localparam logic [7:0] H_STEP = 8'h08;
    localparam logic [7:0] H_HRST = 8'h0C;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_WR_BIT   = 13;
    localparam int ST_BUSY      = 0;
    localparam int ST_PERR      = 1;
    localparam int ST_SLEEP     = 2;
    localparam int ST_STEPBLK   = 3;
    localparam int ST_ERR       = 4;
    localparam int ST_WDRST     = 5;
    localparam int ST_RD_LSB    = 8;

    function automatic logic is_stat(input logic [4:0] a);
        return (a >= A_SR0) && (a <= A_SR3);
    endfunction : is_stat

    function automatic logic is_ctrl(input logic [4:0] a);
        return (a <= A_CR2) || (a == A_CR3);
    endfunction : is_ctrl

    function automatic logic [2:0] ctrl_idx(input logic [4:0] a);
        return (a == A_CR3) ? CR3_IDX : a[2:0];
    endfunction : ctrl_idx
endpackage : msd_pkg

`default_nettype wire

// ### hdl/msd_spi_if.sv
// Pin bundle between the stepper driver and its controller
`default_nettype none

interface msd_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;
    logic step_pulse_input;
    logic hard_reset_input;
    logic reset_watchdog_output_oe;
    logic reset_watchdog_output_n;
    logic err_n;

    // Pull-ups on the released lines
    assign miso     = miso_oe ? miso_o : 1'b1;
    assign reset_watchdog_output_n = ~reset_watchdog_output_oe;

    modport dev (
        input  sclk, cs_n, mosi, step_pulse_input, hard_reset_input,
        output miso_o, miso_oe, reset_watchdog_output_oe, err_n
    );
    modport host (
        output sclk, cs_n, mosi, step_pulse_input, hard_reset_input,
        input  miso, reset_watchdog_output_n, err_n
    );
endinterface : msd_spi_if

`default_nettype wire

// ### hdl/msd_sync.sv
// Three-flop pin synchroniser; output moves when stages two and three agree
`default_nettype none

module msd_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // System
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Pin and result
    input  wire logic d,
    output logic      q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q    <= RST_VAL;
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q <= s3_q;
            end
        end
    end
endmodule : msd_sync

`default_nettype wire

// ### hdl/msd_dev.sv
// Stepper driver end: serial slave, register file, sleep control and watchdog
`default_nettype none

module msd_dev #(
    parameter int MS_CYC = msd_pkg::MS_CYC
) (
    // System
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // Link pins
    msd_spi_if.dev                     spi,
    // Fault events from the power stage, one row per status register
    input  wire logic [3:0][6:0]       status_evt,
    // Control and state toward the motor side
    output logic [msd_pkg::NCTRL-1:0][7:0] ctrl_q,
    output logic                       drivers_hiz_q,
    output logic                       analog_lp_q,
    output logic                       clk_run_q
);
    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic hrst_s;

    msd_sync #(.RST_VAL(1'b0)) u_sclk (.clk(clk), .rst(rst), .ce(ce), .d(spi.sclk), .q(sclk_s));
    msd_sync #(.RST_VAL(1'b1)) u_cs (.clk(clk), .rst(rst), .ce(ce), .d(spi.cs_n), .q(cs_n_s));
    msd_sync #(.RST_VAL(1'b0)) u_mosi (.clk(clk), .rst(rst), .ce(ce), .d(spi.mosi), .q(mosi_s));
    msd_sync #(.RST_VAL(1'b0)) u_hrst (.clk(clk), .rst(rst), .ce(ce), .d(spi.hard_reset_input), .q(hrst_s));

    // Hard reset clears logic regardless of sleep
    logic clr;
    assign clr = rst | hrst_s;

    logic sclk_d_q;
    logic cs_d_q;
    logic rise;
    logic fall;
    logic cs_up;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_d_q <= 1'b0;
            cs_d_q   <= 1'b1;
        end else if (ce) begin
            sclk_d_q <= sclk_s;
            cs_d_q   <= cs_n_s;
        end
    end

    assign rise  = sclk_s & ~sclk_d_q & ~cs_n_s;
    assign fall  = ~sclk_s & sclk_d_q & ~cs_n_s;
    assign cs_up = cs_n_s & ~cs_d_q;

    // ****************************************************
    // Serial shifter
    // ****************************************************
    logic [7:0]       rx_q;
    logic [7:0]       tx_q;
    logic [2:0]       bit_q;
    logic [4:0]       nbits_q;
    logic [4:0]       addr_q;
    logic             data_ph_q;
    logic             wr_cmd_q;
    logic [7:0]       wdata_q;
    logic [3:0]       clr_pend_q;
    logic [3:0][6:0]  stat_q;
    logic             miso_oe_q;
    logic             err_n_q;

    function automatic logic [7:0] rd_reg(input logic [4:0] a);
        logic [1:0] si;
        si = a[1:0];
        if (msd_pkg::is_stat(a)) begin
            return {^stat_q[si], stat_q[si]};
        end else if (msd_pkg::is_ctrl(a)) begin
            return ctrl_q[msd_pkg::ctrl_idx(a)];
        end
        return 8'h00;
    endfunction : rd_reg

    logic byte_end;
    assign byte_end = fall && (bit_q == 3'h0) && (nbits_q != 5'h00);

    // Only pin inputs move this block; nothing here can start a transfer
    always_ff @(posedge clk) begin
        if (clr) begin
            rx_q       <= 8'h00;
            tx_q       <= 8'hFF;
            bit_q      <= 3'h0;
            nbits_q    <= 5'h00;
            addr_q     <= 5'h00;
            data_ph_q  <= 1'b0;
            wr_cmd_q   <= 1'b0;
            wdata_q    <= 8'h00;
            clr_pend_q <= 4'h0;
        end else if (ce) begin
            if (cs_n_s) begin
                bit_q      <= 3'h0;
                nbits_q    <= 5'h00;
                data_ph_q  <= 1'b0;
                wr_cmd_q   <= 1'b0;
                clr_pend_q <= 4'h0;
            end else if (rise) begin
                rx_q  <= {rx_q[6:0], mosi_s};
                bit_q <= bit_q + 3'h1;
                if (nbits_q != 5'h1F) begin
                    nbits_q <= nbits_q + 5'h01;
                end
            end else if (byte_end) begin
                if (data_ph_q) begin
                    wdata_q   <= rx_q;
                    data_ph_q <= 1'b0;
                    tx_q      <= rd_reg(addr_q);
                end else begin
                    addr_q    <= rx_q[4:0];
                    data_ph_q <= rx_q[msd_pkg::CMD_BIT];
                    wr_cmd_q  <= rx_q[msd_pkg::CMD_BIT];
                    tx_q      <= rd_reg(rx_q[4:0]);
                    if (!rx_q[msd_pkg::CMD_BIT] && msd_pkg::is_stat(rx_q[4:0])) begin
                        clr_pend_q[rx_q[1:0]] <= 1'b1;
                    end
                end
            end else if (fall) begin
                tx_q <= {tx_q[6:0], 1'b1};
            end
        end
    end

    // ****************************************************
    // Output pin drive
    // ****************************************************
    always_ff @(posedge clk) begin
        if (clr) begin
            miso_oe_q <= 1'b0;
        end else if (ce) begin
            miso_oe_q <= ~cs_n_s;
        end
    end

    assign spi.miso_o  = tx_q[7];
    assign spi.miso_oe = miso_oe_q;

    // ****************************************************
    // Write commit after deselect
    // ****************************************************
    logic wr_fire;
    assign wr_fire = cs_up && wr_cmd_q && !data_ph_q
                     && (nbits_q == 5'(msd_pkg::WR_BITS))
                     && msd_pkg::is_ctrl(addr_q);

    always_ff @(posedge clk) begin
        if (clr) begin
            ctrl_q <= '0;
        end else if (ce && wr_fire) begin
            ctrl_q[msd_pkg::ctrl_idx(addr_q)] <= wdata_q;
        end
    end

    // ****************************************************
    // Status registers and error flag
    // ****************************************************
    // Events are sampled only at idle cycles; a pulse that starts and ends while selected is lost
    always_ff @(posedge clk) begin
        if (clr) begin
            stat_q  <= '0;
            err_n_q <= 1'b1;
        end else if (ce && cs_n_s) begin
            for (int i = 0; i < 4; i++) begin
                stat_q[i] <= (stat_q[i] & ~{7{clr_pend_q[i]}}) | status_evt[i];
            end
            err_n_q <= ~(|stat_q);
        end
    end

    assign spi.err_n = err_n_q;

    // ****************************************************
    // Sleep control
    // ****************************************************
    logic sleep;
    assign sleep = ctrl_q[msd_pkg::ctrl_idx(msd_pkg::A_CR2)][msd_pkg::SLP_BIT];

    // Registers are never cleared by sleep, only the outputs follow it
    always_ff @(posedge clk) begin
        if (clr) begin
            drivers_hiz_q <= 1'b1;
            analog_lp_q   <= 1'b0;
            clk_run_q     <= 1'b1;
        end else if (ce) begin
            drivers_hiz_q <= sleep | ~ctrl_q[msd_pkg::ctrl_idx(msd_pkg::A_CR2)][msd_pkg::MOTEN_BIT];
            analog_lp_q   <= sleep;
            clk_run_q     <= ~sleep | ~cs_n_s;
        end
    end

    // ****************************************************
    // Watchdog
    // ****************************************************
    logic [15:0] pre_q;
    logic [9:0]  wd_ms_q;
    logic        wd_on_q;
    logic [4:0]  pulse_q;
    logic        por_oe_q;
    logic [3:0]  wdt;
    logic [9:0]  wd_lim;
    logic        kick;
    logic        tick;

    assign wdt    = ctrl_q[0][msd_pkg::WDT_LSB +: 4];
    assign wd_lim = 10'((int'(wdt) + 1) * msd_pkg::WD_BASE_MS);
    assign kick   = wr_fire && (addr_q == msd_pkg::A_WR) && wdata_q[msd_pkg::WATCHDOG_ENABLE_BIT_BIT];
    assign tick   = (pre_q == 16'(MS_CYC - 1));

    // Frozen in sleep so the count picks up where it stopped
    always_ff @(posedge clk) begin
        if (clr) begin
            pre_q   <= 16'h0000;
            wd_ms_q <= 10'h000;
            wd_on_q <= 1'b0;
            pulse_q <= 5'h00;
        end else if (ce) begin
            if (pulse_q != 5'h00) begin
                pulse_q <= pulse_q - 5'h01;
            end
            if (wr_fire && (addr_q == msd_pkg::A_WR) && !wdata_q[msd_pkg::WATCHDOG_ENABLE_BIT_BIT]) begin
                wd_on_q <= 1'b0;
            end else if (kick) begin
                wd_on_q <= 1'b1;
                pre_q   <= 16'h0000;
                wd_ms_q <= 10'h000;
                if (wd_on_q && (wd_ms_q < 10'(msd_pkg::WD_EARLY_MS))) begin
                    pulse_q <= 5'(msd_pkg::WD_PULSE_CYC);
                end
            end else if (wd_on_q && !sleep) begin
                pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
                if (tick) begin
                    if (wd_ms_q + 10'h001 >= wd_lim) begin
                        wd_ms_q <= 10'h000;
                        pulse_q <= 5'(msd_pkg::WD_PULSE_CYC);
                    end else begin
                        wd_ms_q <= wd_ms_q + 10'h001;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            por_oe_q <= 1'b0;
        end else if (ce) begin
            por_oe_q <= (pulse_q != 5'h00);
        end
    end

    assign spi.reset_watchdog_output_oe = por_oe_q;
endmodule : msd_dev

`default_nettype wire

// ### hdl/msd_host.sv
// Controller end: APB-driven serial master with step output and sleep guard
`default_nettype none

module msd_host #(
    parameter int CP_CYC = msd_pkg::CP_CYC
) (
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata_q,
    output logic             pready_q,
    output logic             pslverr_q,
    // Link pins
    msd_spi_if.host          spi
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_LOW  = 3'b001,
        HS_HIGH = 3'b010,
        HS_END  = 3'b011,
        HS_GAP  = 3'b100
    } msd_hst_t;

    logic miso_s;
    logic err_n_s;
    logic wd_n_s;

    msd_sync #(.RST_VAL(1'b1)) u_miso (.clk(clk), .rst(rst), .ce(ce), .d(spi.miso), .q(miso_s));
    msd_sync #(.RST_VAL(1'b1)) u_err (.clk(clk), .rst(rst), .ce(ce), .d(spi.err_n), .q(err_n_s));
    msd_sync #(.RST_VAL(1'b1)) u_wd (.clk(clk), .rst(rst), .ce(ce), .d(spi.reset_watchdog_output_n), .q(wd_n_s));

    // ****************************************************
    // APB access
    // ****************************************************
    msd_hst_t    st_q;
    logic [15:0] tx_q;
    // Whole frame kept apart; tx_q is used up by shifting
    logic [15:0] cmd_q;
    logic [7:0]  rx_q;
    logic [7:0]  rdata_q;
    logic        perr_q;
    logic        retried_q;
    logic        asleep_q;
    logic [15:0] cp_q;
    logic [3:0]  step_q;
    logic        hrst_q;
    logic        acc;
    logic        blk;

    assign acc = psel & penable & pready_q;
    assign blk = asleep_q | (cp_q != 16'h0000) | (step_q != 4'h0);

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= 1'b0;
            if (psel & penable & ~pready_q) begin
                prdata_q <= 32'h00000000;
                unique case (paddr)
                    msd_pkg::H_STAT: prdata_q <= {16'h0000, rdata_q, 2'b00, ~wd_n_s, ~err_n_s,
                                                  blk, asleep_q, perr_q, st_q != HS_IDLE};
                    msd_pkg::H_HRST: prdata_q <= {31'h00000000, hrst_q};
                    msd_pkg::H_CMD, msd_pkg::H_STEP: prdata_q <= 32'h00000000;
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrst_q <= 1'b0;
        end else if (ce && acc && pwrite && (paddr == msd_pkg::H_HRST)) begin
            hrst_q <= pwdata[0];
        end
    end

    // ****************************************************
    // Serial master, one 16-bit packet per select
    // ****************************************************
    logic [4:0] half_q;
    logic [3:0] bit_q;
    logic       sclk_q;
    logic       cs_n_q;
    logic       half_done;
    logic [4:0] t_addr;

    assign half_done = (half_q == 5'(msd_pkg::SPI_HALF - 1));
    assign t_addr    = cmd_q[12:8];

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q      <= HS_IDLE;
            tx_q      <= 16'h0000;
            cmd_q     <= 16'h0000;
            rx_q      <= 8'h00;
            rdata_q   <= 8'h00;
            perr_q    <= 1'b0;
            retried_q <= 1'b0;
            half_q    <= 5'h00;
            bit_q     <= 4'h0;
            sclk_q    <= 1'b0;
            cs_n_q    <= 1'b1;
        end else if (ce) begin
            half_q <= half_done ? 5'h00 : half_q + 5'h01;
            unique case (st_q)
                HS_IDLE: begin
                    half_q <= 5'h00;
                    if (acc && pwrite && (paddr == msd_pkg::H_CMD)) begin
                        tx_q      <= {pwdata[msd_pkg::CMD_WR_BIT], 2'b00,
                                      pwdata[msd_pkg::CMD_ADDR_LSB +: 5], pwdata[7:0]};
                        cmd_q     <= {pwdata[msd_pkg::CMD_WR_BIT], 2'b00,
                                      pwdata[msd_pkg::CMD_ADDR_LSB +: 5], pwdata[7:0]};
                        retried_q <= 1'b0;
                        bit_q     <= 4'h0;
                        cs_n_q    <= 1'b0;
                        st_q      <= HS_LOW;
                    end
                end
                HS_LOW: if (half_done) begin
                    sclk_q <= 1'b1;
                    rx_q   <= {rx_q[6:0], miso_s};
                    st_q   <= HS_HIGH;
                end
                HS_HIGH: if (half_done) begin
                    sclk_q <= 1'b0;
                    if (bit_q == 4'hF) begin
                        st_q <= HS_END;
                    end else begin
                        bit_q <= bit_q + 4'h1;
                        tx_q  <= {tx_q[14:0], 1'b0};
                        st_q  <= HS_LOW;
                    end
                end
                HS_END: if (half_done) begin
                    cs_n_q <= 1'b1;
                    st_q   <= HS_GAP;
                end
                HS_GAP: if (half_done) begin
                    rdata_q <= rx_q;
                    perr_q  <= msd_pkg::is_stat(t_addr) && (rx_q[7] != ^rx_q[6:0]);
                    if (!cmd_q[15] && msd_pkg::is_stat(t_addr) && (rx_q[7] != ^rx_q[6:0]) && !retried_q) begin
                        retried_q <= 1'b1;
                        tx_q      <= cmd_q;
                        bit_q     <= 4'h0;
                        cs_n_q    <= 1'b0;
                        st_q      <= HS_LOW;
                    end else begin
                        st_q <= HS_IDLE;
                    end
                end
            endcase
        end
    end

    // Shift register is left-aligned after each shift, MSB drives the line
    assign spi.sclk = sclk_q;
    assign spi.cs_n = cs_n_q;
    assign spi.mosi = tx_q[15];
    assign spi.hard_reset_input = hrst_q;

    // ****************************************************
    // Sleep tracking and step pulses
    // ****************************************************
    logic wr_done;
    assign wr_done = (st_q == HS_GAP) && half_done && cmd_q[15] && (t_addr == msd_pkg::A_CR2);

    // Own copy of the sleep bit; the pin pulse is refused while it or charge pump wait stands
    always_ff @(posedge clk) begin
        if (rst || hrst_q) begin
            asleep_q <= 1'b0;
            cp_q     <= 16'h0000;
        end else if (ce) begin
            if (cp_q != 16'h0000) begin
                cp_q <= cp_q - 16'h0001;
            end
            if (wr_done) begin
                asleep_q <= cmd_q[msd_pkg::SLP_BIT];
                if (asleep_q && !cmd_q[msd_pkg::SLP_BIT]) begin
                    cp_q <= 16'(CP_CYC);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step_q <= 4'h0;
        end else if (ce) begin
            if (step_q != 4'h0) begin
                step_q <= step_q - 4'h1;
            end else if (acc && pwrite && (paddr == msd_pkg::H_STEP) && !blk) begin
                step_q <= 4'(msd_pkg::STEP_HI_CYC);
            end
        end
    end

    logic step_o_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            step_o_q <= 1'b0;
        end else if (ce) begin
            step_o_q <= (step_q != 4'h0);
        end
    end

    assign spi.step_pulse_input = step_o_q;
endmodule : msd_host

`default_nettype wire

// ### testbench/msd_link_chk.sv
// Link pin checker for the stepper driver bus
`default_nettype none
module msd_link_chk (
    // System
    input wire logic clk,
    input wire logic rst,
    // Link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso,
    input wire logic reset_watchdog_output_oe,
    input wire logic err_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence sel_run; !cs_n [*6]; endsequence
    sequence clk_hi; sclk && $past(sclk); endsequence
    idle_clk_a: assert property (cs_n |-> !sclk) else $error("idle clock");
    out_release_a: assert property (cs_n [*6] |-> !miso_oe) else $error("idle drive");
    pull_up_a: assert property (!miso_oe |-> miso) else $error("line low");
    slave_only_a: assert property ($rose(miso_oe) |-> !cs_n) else $error("unselected drive");
    out_hold_a: assert property (clk_hi |-> $stable(miso_o)) else $error("output moved");
    in_hold_a: assert property (clk_hi |-> $stable(mosi)) else $error("input moved");
    err_hold_a: assert property (sel_run |-> $stable(err_n)) else $error("flag moved");
    wd_width_a: assert property ($fell(reset_watchdog_output_oe) |-> $past(reset_watchdog_output_oe, 16) && !$past(reset_watchdog_output_oe, 17))
        else $error("pulse width");
endmodule : msd_link_chk
`default_nettype wire

// ### testbench/msd_bench.sv
// Bench joining controller and driver over the link
`default_nettype none
module msd_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pr, hiz, alp, run;
    logic [7:0] pa = 8'h00, d;
    logic [4:0] s;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [3:0][6:0] evt = '0;
    logic [4:0][7:0] cq, ex = '0;
    int fails = 0, tests_run = 0, n;
    msd_spi_if bus ();
    always #20 clk = ~clk;
    // Short watchdog base so code 15 fits the run
    msd_dev #(.MS_CYC(100)) i_msd_dev (.clk(clk), .rst(rst), .ce(1'b1), .spi(bus), .status_evt(evt),
        .ctrl_q(cq), .drivers_hiz_q(hiz), .analog_lp_q(alp), .clk_run_q(run));
    msd_host #(.CP_CYC(20)) i_msd_host (.clk(clk), .rst(rst), .ce(1'b1), .paddr(pa), .psel(psel), .penable(pen),
        .pwrite(pa != msd_pkg::H_STAT), .pwdata(pwd), .prdata_q(prd), .pready_q(pr), .pslverr_q(), .spi(bus));
    msd_link_chk i_chk (.clk(clk), .rst(rst), .sclk(bus.sclk), .cs_n(bus.cs_n), .mosi(bus.mosi),
        .miso_o(bus.miso_o), .miso_oe(bus.miso_oe), .miso(bus.miso), .reset_watchdog_output_oe(bus.reset_watchdog_output_oe), .err_n(bus.err_n));
    task automatic complete_run;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t %h %h", $time, g, e);
        end
    endtask : chk
    task automatic guard(input int lim);
        fails += int'(n >= lim);
        if (n >= lim) complete_run();
    endtask : guard
    task automatic apb(input logic [7:0] a, input logic [31:0] v);
        {psel, pa, pwd} <= {1'b1, a, v};
        @(posedge clk) pen <= 1'b1;
        n = 0;
        do @(posedge clk); while (pr !== 1'b1 && ++n < 60);
        rd = prd;
        {psel, pen} <= 2'b00;
        @(posedge clk);
        guard(60);
    endtask : apb
    task automatic cmd(input logic w, input logic [4:0] a, input logic [7:0] v);
        int k;
        apb(msd_pkg::H_CMD, {18'h0, w, a, v});
        // Busy covers the whole frame, so poll rather than count
        for (k = 0; k < 300; k++) begin
            apb(msd_pkg::H_STAT, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        n = k;
        guard(300);
    endtask : cmd
    initial begin
        void'($urandom(32'h7112));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 1; i < 4; i++) begin
            d = 8'($urandom);
            s = i == 3 ? 5'h08 : 5'(i);
            ex[i == 3 ? 4 : i] = d;
            cmd(1'b1, s, d);
            cmd(1'b0, s, 8'h00);
            chk(rd[15:8], d);
            chk(cq, ex);
        end
        $display("control registers done");
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            evt[i] <= d[6:0];
            repeat (4) @(posedge clk);
            evt[i] <= 7'h00;
            s = 5'(4 + i);
            cmd(1'b0, s, 8'h00);
            chk(rd[15:8], {^d[6:0], d[6:0]});
            cmd(1'b1, s, 8'hFF);
            cmd(1'b0, s, 8'h00);
            chk(rd[15:8], 8'h00);
            chk(cq, ex);
        end
        $display("status registers done");
        cmd(1'b1, 5'h03, 8'hC0);
        ex[3] = 8'hC0;
        chk({hiz, alp, run}, 3'b110);
        cmd(1'b0, 5'h01, 8'h00);
        chk({rd[2], rd[15:8], cq}, {1'b1, ex[1], ex});
        apb(msd_pkg::H_STEP, 32'h1);
        @(posedge clk);
        chk(bus.step_pulse_input, 1'b0);
        apb(msd_pkg::H_HRST, 32'h1);
        repeat (8) @(posedge clk);
        apb(msd_pkg::H_HRST, 32'h0);
        repeat (8) @(posedge clk);
        chk({cq, alp}, 41'h0);
        apb(msd_pkg::H_STEP, 32'h1);
        @(posedge clk);
        chk(bus.step_pulse_input, 1'b1);
        $display("sleep done");
        cmd(1'b1, 5'h00, 8'hF8);
        for (n = 0; bus.reset_watchdog_output_n !== 1'b0 && n < 52000; n++) @(posedge clk);
        chk(n > 51000 && n <= 51200, 1'b1);
        cmd(1'b1, 5'h00, 8'h80);
        for (n = 0; bus.reset_watchdog_output_n !== 1'b0 && n < 100; n++) @(posedge clk);
        chk(n < 100, 1'b1);
        $display("watchdog done");
        complete_run();
    end
endmodule : msd_bench
`default_nettype wire
